// *** src/mmuc_pkg.sv ***
// constants and types shared by the multimode up-counter design
package mmuc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_CMP = 8'h08;
    localparam logic [7:0] ADDR_GATE = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    // timer_control_one fields
    localparam int C1_MODE_LSB = 0;
    localparam int C1_RUN_LSB = 2;
    localparam int C1_SRC_LSB = 4;
    localparam int C1_CLR_BIT = 7;
    localparam int C1_LOWSPD_BIT = 8;
    localparam int C1_W = 9;
    // timer_control_two fields
    localparam int C2_SEG_BIT = 0;
    localparam int C2_GSRC_LSB = 1;
    localparam int C2_GEDG_BIT = 3;
    localparam int C2_GCLK_LSB = 4;
    localparam int C2_PINBLK_BIT = 6;
    localparam int C2_DIVSTG_BIT = 7;
    localparam int C2_W = 8;
    // gate_period_reg and timer_status_reg fields
    localparam int GP_HI_LSB = 0;
    localparam int GP_LO_LSB = 4;
    localparam int ST_OVF_BIT = 0;
    localparam int ST_GATE_BIT = 1;
    // values after reset
    localparam logic [8:0] C1_RST = 9'h000;
    localparam logic [7:0] C2_RST = 8'h00;
    localparam logic [7:0] GP_RST = 8'h00;
    localparam logic [17:0] CMP_RST = 18'h00001;
    // counter geometry
    localparam int CNT_W = 18;
    localparam int CMP_LOW_BITS = 11;
    // run_control codes
    localparam logic [1:0] RUN_STOP = 2'h0;
    localparam logic [1:0] RUN_START = 2'h2;
    // gate_source_select codes
    localparam logic [1:0] GSRC_PIN = 2'h0;
    localparam logic [1:0] GSRC_INT = 2'h1;
    localparam logic [1:0] GSRC_COMP = 2'h2;
    // source_clock_select codes
    localparam logic [2:0] SRC_FC = 3'h5;
    localparam logic [2:0] SRC_FS = 3'h6;
    localparam logic [2:0] SRC_EXT = 3'h7;
    // prescaler widths
    localparam int FC_DIV_W = 23;
    localparam int FS_DIV_W = 15;
    // window gate period base
    localparam logic [4:0] GATE_FULL = 5'h10;
    // synchroniser lanes: ext pin, low clock, companion output
    localparam int SYNC_W = 3;
    typedef enum logic [1:0] {
        MODE_TIMER, MODE_EVENT, MODE_PULSE, MODE_FREQ
    } mmuc_mode_t;
    typedef enum logic [1:0] {
        GATE_IDLE, GATE_HIGH, GATE_LOW
    } mmuc_gate_st_t;
endpackage

// *** src/mmuc_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module mmuc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mmuc_pkg::SYNC_W-1:0] async_in,
    output logic [mmuc_pkg::SYNC_W-1:0] level_out
);
    logic [mmuc_pkg::SYNC_W-1:0] s1_q;
    logic [mmuc_pkg::SYNC_W-1:0] s2_q;
    logic [mmuc_pkg::SYNC_W-1:0] s3_q;
    logic [mmuc_pkg::SYNC_W-1:0] agree;

    // a lane changes only once stages two and three agree
    assign agree = ~(s2_q ^ s3_q);

    // s1 feeds only s2, so metastability never reaches the filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_out <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_out <= (agree & s2_q) | (~agree & level_out);
        end
    end
endmodule // mmuc_sync

// *** src/mmuc_gate_gen.sv ***
// internal window gate generator: high and low periods in gate ticks
`timescale 1ns/10ps
module mmuc_gate_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic tick,
    input wire logic [3:0] high_set,
    input wire logic [3:0] low_set,
    output logic gate
);
    mmuc_pkg::mmuc_gate_st_t st_q;
    logic [4:0] left_q;
    logic [4:0] high_len;
    logic [4:0] low_len;

    // period lengths are sixteen minus the setting
    assign high_len = mmuc_pkg::GATE_FULL - {1'b0, high_set};
    assign low_len = mmuc_pkg::GATE_FULL - {1'b0, low_set};

    // first high waits for a divider tick, so start may lag one tick
    // low length is sampled only on entry to the low period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= mmuc_pkg::GATE_IDLE;
            left_q <= 5'h00;
        end else if (!run) begin
            st_q <= mmuc_pkg::GATE_IDLE;
            left_q <= 5'h00;
        end else if (tick) begin
            case (st_q)
                mmuc_pkg::GATE_IDLE: begin
                    st_q <= mmuc_pkg::GATE_HIGH;
                    left_q <= high_len;
                end
                mmuc_pkg::GATE_HIGH: begin
                    if (left_q <= 5'h01) begin
                        st_q <= mmuc_pkg::GATE_LOW;
                        left_q <= low_len;
                    end else begin
                        left_q <= left_q - 5'h01;
                    end
                end
                mmuc_pkg::GATE_LOW: begin
                    if (left_q <= 5'h01) begin
                        st_q <= mmuc_pkg::GATE_HIGH;
                        left_q <= high_len;
                    end else begin
                        left_q <= left_q - 5'h01;
                    end
                end
                default: begin
                    st_q <= mmuc_pkg::GATE_IDLE;
                    left_q <= 5'h00;
                end
            endcase
        end
    end

    // gate is high only in the counting period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate <= 1'b0;
        end else begin
            gate <= run && (st_q == mmuc_pkg::GATE_HIGH);
        end
    end
endmodule // mmuc_gate_gen

// *** src/mmuc_top.sv ***
// multimode 18-bit up-counter with apb register access
`timescale 1ns/10ps
module mmuc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic low_clk_in,
    input wire logic companion_timer_output,
    output logic timer_one_irq,
    output logic shared_output_pin
);
    // register state
    logic [8:0] ctrl1_q;
    logic [7:0] ctrl2_q, gate_period_q;
    logic [17:0] cmp_q, cnt_q;
    logic ovf_q;

    // synchronised inputs and their previous levels
    logic [2:0] sync_lvl;
    logic ext_count_input, fs_lvl, comp_lvl, ext_prev_q, fs_prev_q;
    // prescalers
    logic [22:0] fc_div_q;
    logic [14:0] fs_div_q;
    // edge history
    logic src_prev_q, gclk_prev_q, gate_prev_q, pand_prev_q, fand_prev_q;

    // control fields
    mmuc_pkg::mmuc_mode_t mode;
    logic [1:0] run_control, gate_source_select, gate_clock_select;
    logic [2:0] source_clock_select;
    logic low_speed, input_edge_select, gate_irq_edge_select;
    logic companion_pin_block, divider_stage_select, running;
    logic [3:0] gate_high_setting, gate_low_setting;

    // field extraction
    assign mode = mmuc_pkg::mmuc_mode_t'(
        ctrl1_q[mmuc_pkg::C1_MODE_LSB +: 2]);
    assign run_control = ctrl1_q[mmuc_pkg::C1_RUN_LSB +: 2];
    assign source_clock_select = ctrl1_q[mmuc_pkg::C1_SRC_LSB +: 3];
    assign low_speed = ctrl1_q[mmuc_pkg::C1_LOWSPD_BIT];
    assign input_edge_select = ctrl2_q[mmuc_pkg::C2_SEG_BIT];
    assign gate_source_select = ctrl2_q[mmuc_pkg::C2_GSRC_LSB +: 2];
    assign gate_irq_edge_select = ctrl2_q[mmuc_pkg::C2_GEDG_BIT];
    assign gate_clock_select = ctrl2_q[mmuc_pkg::C2_GCLK_LSB +: 2];
    assign companion_pin_block = ctrl2_q[mmuc_pkg::C2_PINBLK_BIT];
    assign divider_stage_select = ctrl2_q[mmuc_pkg::C2_DIVSTG_BIT];
    assign gate_high_setting = gate_period_q[mmuc_pkg::GP_HI_LSB +: 4];
    assign gate_low_setting = gate_period_q[mmuc_pkg::GP_LO_LSB +: 4];
    assign running = (run_control == mmuc_pkg::RUN_START);

    // apb decode
    logic setup_ph, wr_acc, hit, counter_clear_cmd;
    logic wr_ctrl1, wr_ctrl2, wr_cmp, wr_gate;
    logic [1:0] new_run;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;
    assign hit = (paddr == mmuc_pkg::ADDR_CTRL1)
        || (paddr == mmuc_pkg::ADDR_CTRL2)
        || (paddr == mmuc_pkg::ADDR_CMP)
        || (paddr == mmuc_pkg::ADDR_GATE)
        || (paddr == mmuc_pkg::ADDR_STAT);
    assign wr_ctrl1 = wr_acc && (paddr == mmuc_pkg::ADDR_CTRL1);
    assign wr_ctrl2 = wr_acc && (paddr == mmuc_pkg::ADDR_CTRL2);
    assign wr_cmp = wr_acc && (paddr == mmuc_pkg::ADDR_CMP);
    assign wr_gate = wr_acc && (paddr == mmuc_pkg::ADDR_GATE);
    // clear is a write-one strobe; the bit is stored in ctrl1_q but reads back zero
    assign counter_clear_cmd = wr_ctrl1
        && pwdata[mmuc_pkg::C1_CLR_BIT];
    assign new_run = pwdata[mmuc_pkg::C1_RUN_LSB +: 2];

    // external pin, low clock and companion output cross domains
    mmuc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({companion_timer_output, low_clk_in, ext_count_pin}),
        .level_out(sync_lvl)
    );
    assign ext_count_input = sync_lvl[0];
    assign fs_lvl = sync_lvl[1];
    assign comp_lvl = sync_lvl[2];

    // input edges
    logic ext_fall, ext_rise, fs_rise;
    assign ext_fall = ext_prev_q && !ext_count_input;
    assign ext_rise = !ext_prev_q && ext_count_input;
    assign fs_rise = !fs_prev_q && fs_lvl;

    // internal source clock as a divider level; fast means every cycle
    logic src_fast, src_lvl, src_tick;
    assign src_fast = (source_clock_select == mmuc_pkg::SRC_FC);
    assign src_lvl =
        (source_clock_select == 3'h0) ?
            (divider_stage_select ? fs_div_q[14] : fc_div_q[22]) :
        (source_clock_select == 3'h1) ?
            (divider_stage_select ? fs_div_q[4] : fc_div_q[12]) :
        (source_clock_select == 3'h2) ?
            (divider_stage_select ? fs_div_q[2] : fc_div_q[10]) :
        (source_clock_select == 3'h3) ? fc_div_q[6] :
        (source_clock_select == 3'h4) ? fc_div_q[2] :
        (source_clock_select == mmuc_pkg::SRC_FS) ? fs_lvl :
        (source_clock_select == mmuc_pkg::SRC_EXT) ? ext_count_input :
        1'b1;
    assign src_tick = src_fast || (src_prev_q && !src_lvl);

    // gate clock taps; the reserved code gives no ticks
    logic gclk_lvl;
    logic gclk_tick;
    assign gclk_lvl =
        (gate_clock_select == 2'h0) ?
            (divider_stage_select ? fs_div_q[3] : fc_div_q[11]) :
        (gate_clock_select == 2'h1) ?
            (divider_stage_select ? fs_div_q[4] : fc_div_q[12]) :
        (gate_clock_select == 2'h2) ?
            (divider_stage_select ? fs_div_q[5] : fc_div_q[13]) :
        1'b0;
    assign gclk_tick = gclk_prev_q && !gclk_lvl;

    // internal window gate generator
    logic int_gate;
    mmuc_gate_gen u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .run(running && (mode == mmuc_pkg::MODE_FREQ)),
        .tick(gclk_tick),
        .high_set(gate_high_setting),
        .low_set(gate_low_setting),
        .gate(int_gate)
    );

    // window gate source selection
    logic gate_lvl;
    logic gate_fall;
    logic gate_rise;
    assign gate_lvl =
        (gate_source_select == mmuc_pkg::GSRC_PIN) ? ext_count_input :
        (gate_source_select == mmuc_pkg::GSRC_INT) ? int_gate :
        (gate_source_select == mmuc_pkg::GSRC_COMP) ? comp_lvl :
        1'b0;
    assign gate_fall = gate_prev_q && !gate_lvl;
    assign gate_rise = !gate_prev_q && gate_lvl;

    // pulse mode counts falls of input and source clock; a fall of
    // the input while the clock is high ends with one extra count
    logic pand_lvl;
    logic pand_fall;
    assign pand_lvl = ext_count_input && (src_fast || src_lvl);
    assign pand_fall = pand_prev_q && (!pand_lvl || src_fast);

    // frequency mode: falling-only counts the fall of input and gate
    logic fand_lvl;
    logic freq_inc;
    assign fand_lvl = ext_count_input && gate_lvl;
    assign freq_inc = input_edge_select ?
        (((ext_fall || ext_rise) && gate_lvl) || gate_fall) :
        (fand_prev_q && !fand_lvl);

    // increment request per mode
    logic inc;
    logic match_mode;
    always_comb begin
        inc = 1'b0;
        match_mode = 1'b0;
        case (mode)
            mmuc_pkg::MODE_TIMER: begin
                inc = src_tick;
                match_mode = 1'b1;
            end
            mmuc_pkg::MODE_EVENT: begin
                inc = ext_fall;
                match_mode = 1'b1;
            end
            mmuc_pkg::MODE_PULSE: inc = pand_fall;
            mmuc_pkg::MODE_FREQ: inc = freq_inc;
            default: inc = 1'b0;
        endcase
        inc = inc && running;
    end

    // compare on the next count; low 11 bits drop out at low speed with the fast source
    logic [17:0] cnt_next, cmp_mask;
    logic match, wrap;
    assign cnt_next = cnt_q + 18'h00001;
    assign cmp_mask = (low_speed && src_fast) ?
        {7'h7F, 11'h000} : 18'h3FFFF;
    assign match = match_mode && inc
        && ((cnt_next & cmp_mask) == (cmp_q & cmp_mask));
    assign wrap = inc && (cnt_q == 18'h3FFFF);

    // interrupt causes
    logic gate_irq, stop_irq, start_irq;
    assign gate_irq =
        ((mode == mmuc_pkg::MODE_PULSE) && running
            && (ext_fall || (ext_rise && gate_irq_edge_select))) ||
        ((mode == mmuc_pkg::MODE_FREQ) && running
            && (gate_fall || (gate_rise && gate_irq_edge_select)));
    assign stop_irq = wr_ctrl1 && (mode == mmuc_pkg::MODE_PULSE)
        && ext_count_input && running
        && (new_run == mmuc_pkg::RUN_STOP);
    assign start_irq = wr_ctrl1 && (mode == mmuc_pkg::MODE_PULSE)
        && ext_count_input && !running && gate_irq_edge_select
        && (new_run == mmuc_pkg::RUN_START);

    // gate status: only the frequency mode shows the gate level
    logic gate_status_flag;
    assign gate_status_flag = running && (mode == mmuc_pkg::MODE_FREQ)
        && gate_lvl;

    // read mux; reserved bits read zero
    logic [31:0] rd_mux;
    assign rd_mux =
        (paddr == mmuc_pkg::ADDR_CTRL1) ? {23'h000000,
            ctrl1_q & ~(9'h001 << mmuc_pkg::C1_CLR_BIT)} :
        (paddr == mmuc_pkg::ADDR_CTRL2) ? {24'h000000, ctrl2_q} :
        (paddr == mmuc_pkg::ADDR_CMP) ? {14'h0000, cnt_q} :
        (paddr == mmuc_pkg::ADDR_GATE) ? {24'h000000, gate_period_q} :
        (paddr == mmuc_pkg::ADDR_STAT) ? {30'h00000000,
            gate_status_flag, ovf_q} :
        32'h00000000;

    // apb answer: ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && !hit;
            prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= mmuc_pkg::C1_RST;
            ctrl2_q <= mmuc_pkg::C2_RST;
            cmp_q <= mmuc_pkg::CMP_RST;
            gate_period_q <= mmuc_pkg::GP_RST;
        end else begin
            if (wr_ctrl1) begin
                ctrl1_q <= pwdata[8:0];
            end
            if (wr_ctrl2) begin
                ctrl2_q <= pwdata[7:0];
            end
            if (wr_cmp) begin
                cmp_q <= pwdata[17:0];
            end
            if (wr_gate) begin
                gate_period_q <= pwdata[7:0];
            end
        end
    end

    // counter; stopping keeps the value so counting resumes from it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 18'h00000;
        end else if (counter_clear_cmd) begin
            cnt_q <= 18'h00000;
        end else if (match) begin
            cnt_q <= 18'h00000;
        end else if (inc) begin
            cnt_q <= cnt_next;
        end
    end

    // overflow is sticky; a wrap in the clear cycle still sets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= (ovf_q && !counter_clear_cmd) || wrap;
        end
    end

    // free-running prescalers; the low clock stage steps on its rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_div_q <= 23'h000000;
            fs_div_q <= 15'h0000;
        end else begin
            fc_div_q <= fc_div_q + 23'h000001;
            if (fs_rise) begin
                fs_div_q <= fs_div_q + 15'h0001;
            end
        end
    end

    // edge history for every level that is edge-detected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 1'b0;
            fs_prev_q <= 1'b0;
            src_prev_q <= 1'b0;
            gclk_prev_q <= 1'b0;
            gate_prev_q <= 1'b0;
            pand_prev_q <= 1'b0;
            fand_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_count_input;
            fs_prev_q <= fs_lvl;
            src_prev_q <= src_lvl;
            gclk_prev_q <= gclk_lvl;
            gate_prev_q <= gate_lvl;
            pand_prev_q <= pand_lvl;
            fand_prev_q <= fand_lvl;
        end
    end

    // outputs from flops; irq is high for one cycle after each cycle holding any event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_irq <= 1'b0;
            shared_output_pin <= 1'b0;
        end else begin
            timer_one_irq <= match || gate_irq || stop_irq || start_irq;
            // routing only; the companion timer keeps running
            shared_output_pin <= !companion_pin_block
                && comp_lvl;
        end
    end
endmodule // mmuc_top

// *** test/mmuc_checker.sv ***
// checker for the apb answer, interrupt and pin ports of the counter
`timescale 1ns/10ps
module mmuc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_count_pin,
    input wire logic low_clk_in,
    input wire logic companion_timer_output,
    input wire logic timer_one_irq,
    input wire logic shared_output_pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // apb phases as named steps
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(logic [7:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    ready_next_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_unmap_a: assert property (setup_s ##0 paddr > 8'h10 |=> pslverr)
        else $error("unmapped access not refused");
    err_map_a: assert property (setup_s ##0 paddr[1:0] == 2'h0
        && paddr <= 8'h10 |=> !pslverr) else $error("mapped access refused");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    cnt_width_a: assert property (rd_s(8'h08) |-> prdata[31:18] == 14'h0)
        else $error("counter wider than 18 bits");
    clr_strobe_a: assert property (rd_s(8'h00) |-> !prdata[7])
        else $error("clear command reads back set");
    irq_pulse_a: assert property (timer_one_irq |=> !timer_one_irq)
        else $error("interrupt longer than a pulse");
    pin_low_a: assert property (!companion_timer_output [*8]
        |-> !shared_output_pin) else $error("pin follows no source");
endmodule // mmuc_checker
bind mmuc_top mmuc_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(ext_count_pin), .low_clk_in(low_clk_in),
    .companion_timer_output(companion_timer_output),
    .timer_one_irq(timer_one_irq), .shared_output_pin(shared_output_pin));

// *** test/mmuc_src.sv ***
// external pulse source and companion timer output model
`timescale 1ns/10ps
module mmuc_src (
    input wire logic pclk,
    output logic ext_pin,
    output logic comp_out,
    output logic low_clk
);
    initial begin
        ext_pin = 1'b0;
        comp_out = 1'b0;
        low_clk = 1'b0;
    end
    // low clock runs free, far below pclk
    always #61 low_clk = ~low_clk;
    // eight cycles high and nine low put the rate at pclk over seventeen
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk) ext_pin <= 1'b1;
            repeat (8) @(posedge pclk);
            ext_pin <= 1'b0;
            repeat (8) @(posedge pclk);
        end
    endtask
endmodule // mmuc_src

// *** test/mmuc_top_tb.sv ***
// self-checking bench for the multimode up-counter
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module mmuc_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, pin, ext, comp, lowc, err;
    int fail_count = 0, checks = 0, irqs = 0, cyc = 0, t0;
    mmuc_src src (.pclk(pclk), .ext_pin(ext), .comp_out(comp),
        .low_clk(lowc));
    mmuc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_pin(ext), .low_clk_in(lowc),
        .companion_timer_output(comp), .timer_one_irq(irq),
        .shared_output_pin(pin));
    initial forever #4 pclk = ~pclk;
    // tallies move by nba, so a task reading them at an edge never
    // races the update made at that same edge
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irqs <= irqs + 1;
        end
    end
    // one transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // control one word: mode, run code, source, clear
    function automatic logic [31:0] c1(input int m, r, s, clr);
        return 32'(m | r << 2 | s << 4 | clr << 7);
    endfunction
    task automatic t_regs();
        apb(0, mmuc_pkg::ADDR_CTRL2, 0);
        `CHK(rd, 32'h0)
        apb(0, mmuc_pkg::ADDR_CMP, 0);
        `CHK(rd, 32'h0)
        apb(0, mmuc_pkg::ADDR_STAT, 0);
        `CHK(rd, 32'h0)
        apb(0, 8'h20, 0);
        `CHK(err, 1'b1)
    endtask
    task automatic t_timer();
        int t1;
        apb(1, mmuc_pkg::ADDR_CMP, 5);
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(0, 2, 5, 1));
        t0 = irqs;
        while (irqs == t0) @(posedge pclk);
        t0 = irqs;
        t1 = cyc;
        while (irqs == t0) @(posedge pclk);
        `CHK(cyc - t1, 5)
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(0, 0, 5, 1));
        apb(0, mmuc_pkg::ADDR_CMP, 0);
        `CHK(rd, 32'h0)
    endtask
    task automatic t_event();
        apb(1, mmuc_pkg::ADDR_CMP, 3);
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(1, 2, 7, 1));
        t0 = irqs;
        src.pulses(5);
        repeat (8) @(posedge pclk);
        `CHK(irqs - t0, 1)
        apb(0, mmuc_pkg::ADDR_CMP, 0);
        `CHK(rd, 32'h2)
    endtask
    task automatic t_pulse();
        apb(1, mmuc_pkg::ADDR_CMP, 32'h3FFFF);
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(2, 2, 5, 1));
        t0 = irqs;
        src.pulses(1);
        repeat (8) @(posedge pclk);
        `CHK(irqs - t0, 1)
        apb(0, mmuc_pkg::ADDR_CMP, 0);
        `CHK(rd >= 7 && rd <= 9, 1'b1)
        // no clear: the second window adds to the first
        src.pulses(1);
        repeat (8) @(posedge pclk);
        apb(0, mmuc_pkg::ADDR_CMP, 0);
        `CHK(rd >= 15 && rd <= 17, 1'b1)
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(2, 0, 5, 1));
        apb(1, mmuc_pkg::ADDR_CTRL2, 32'h08);
        @(posedge pclk) src.ext_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        t0 = irqs;
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(2, 2, 5, 0));
        repeat (4) @(posedge pclk);
        `CHK(irqs - t0, 1)
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(2, 0, 5, 0));
        repeat (4) @(posedge pclk);
        `CHK(irqs - t0, 2)
        src.ext_pin <= 1'b0;
    endtask
    task automatic t_freq();
        apb(1, mmuc_pkg::ADDR_CTRL2, 32'h04);
        apb(1, mmuc_pkg::ADDR_CTRL1, c1(3, 2, 7, 1));
        @(posedge pclk) src.comp_out <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(pin, 1'b1)
        apb(0, mmuc_pkg::ADDR_STAT, 0);
        `CHK(rd[1], 1'b1)
        t0 = irqs;
        src.pulses(4);
        src.comp_out <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK(irqs - t0, 1)
        apb(0, mmuc_pkg::ADDR_CMP, 0);
        `CHK(rd, 32'h4)
        apb(0, mmuc_pkg::ADDR_STAT, 0);
        `CHK(rd[1], 1'b0)
        apb(1, mmuc_pkg::ADDR_CTRL2, 32'h44);
        @(posedge pclk) src.comp_out <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(pin, 1'b0)
    endtask
    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_timer();
        t_event();
        t_pulse();
        t_freq();
        stop_test();
    end
endmodule // mmuc_top_tb
